// *** verilog/fwsr_poller.sv ***
// Purpose: host-side status poller for an embedded program/erase
// Assumes: software has already written the command sequence
// Notes: data polling or toggle polling, selected per start
`timescale 1ns/1ps
module fwsr_poller
    import fwsr_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [21:0] flash_addr,
    input wire logic [7:0] flash_dq_in,
    output logic [7:0] flash_dq_out,
    output logic flash_dq_oe_n,
    output logic flash_oe_n,
    output logic flash_we_n,
    input wire logic ready_busy_n
);
    import fwsr_pkg::*;
    typedef enum logic [6:0] {
        P_IDLE = 7'b0000001,
        P_RD1 = 7'b0000010,   // first status read
        P_RD2 = 7'b0000100,   // second status read
        P_RECHK = 7'b0001000, // recheck after timeout bit
        P_FINAL = 7'b0010000, // later read for clean data
        P_RST = 7'b0100000,   // reset command write
        P_WAIT = 7'b1000000   // waiting for a bus cycle
    } fwsr_st_type;
    fwsr_st_type st_r; // poller state
    fwsr_st_type ret_r; // state to enter after cycle
    logic [21:0] addr_r; // poll address
    logic [7:0] exp_r; // expected datum
    logic erase_r; // erase operation
    logic tog_r; // toggle method
    logic busy_r, done_r, fail_r, sel_r; // status bits
    logic rdy_r; // sampled ready/busy pin
    logic [7:0] prev_r; // previous status read
    logic go_r, wr_r; // cycle request
    logic [7:0] rdata; // cycle result
    logic cyc_done; // cycle finished
    logic ack_r; // bus answer cycle

    // true when a status read says the operation is finished
    function automatic logic op_done(input logic [7:0] d, input logic [7:0] p,
        input logic tog, input logic er, input logic [7:0] e);
        if (tog) begin
            op_done = (d[TOG1_BIT] == p[TOG1_BIT]);
        end else if (er) begin
            op_done = d[POLL_BIT];
        end else begin
            op_done = (d[POLL_BIT] == e[POLL_BIT]);
        end
    endfunction

    fwsr_bus_cycle u_cyc (
        .clk(clk),
        .rst(rst),
        .go(go_r),
        .wr(wr_r),
        .wdata(CMD_RESET),
        .dq_in(flash_dq_in),
        .rdata(rdata),
        .done(cyc_done),
        .oe_n(flash_oe_n),
        .we_n(flash_we_n),
        .dq_oe_n(flash_dq_oe_n)
    );

    // reset command is the only data this poller ever drives
    always_ff @(posedge clk) begin
        if (rst) begin
            flash_dq_out <= 8'h00;
        end else begin
            flash_dq_out <= CMD_RESET;
        end
    end

    // address output follows the poll address
    always_ff @(posedge clk) begin
        if (rst) begin
            flash_addr <= '0;
        end else begin
            flash_addr <= addr_r;
        end
    end

    // ready/busy pin sampled as status only, never trusted alone
    always_ff @(posedge clk) begin
        if (rst) begin
            rdy_r <= 1'b1;
        end else begin
            rdy_r <= ready_busy_n;
        end
    end

    // avalon slave: one wait cycle, then answer
    always_ff @(posedge clk) begin
        if (rst) begin
            ack_r <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0;
        end else begin
            ack_r <= (avs_read | avs_write) & ~ack_r;
            avs_waitrequest <= ~((avs_read | avs_write) & ~ack_r);
            unique case (avs_address)
                REG_ADDR: avs_readdata <= {10'h0, addr_r};
                REG_DATA: avs_readdata <= {24'h0, exp_r};
                REG_STAT: avs_readdata <= {27'h0, sel_r, rdy_r, fail_r,
                    done_r, busy_r};
                default: avs_readdata <= 32'h0; // control and unmapped
            endcase
        end
    end

    // configuration registers, host-written only while idle; exp_r also loaded in P_FINAL
    always_ff @(posedge clk) begin
        if (rst) begin
            addr_r <= '0;
            exp_r <= 8'h00;
            erase_r <= 1'b0;
            tog_r <= 1'b0;
        end else if (avs_write && ack_r && !busy_r) begin
            if (avs_address == REG_ADDR) begin
                addr_r <= avs_writedata[21:0];
            end
            if (avs_address == REG_DATA) begin
                exp_r <= avs_writedata[7:0];
            end
            if (avs_address == REG_CTRL) begin
                erase_r <= avs_writedata[CTRL_ERASE];
                tog_r <= avs_writedata[CTRL_TOGGLE];
            end
        end else if (st_r == P_FINAL) begin
            // done pulse was spent in P_WAIT; rdata still holds the read
            exp_r <= rdata;
        end
    end

    // polling sequencer
    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= P_IDLE;
            ret_r <= P_IDLE;
            go_r <= 1'b0;
            wr_r <= 1'b0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
            fail_r <= 1'b0;
            sel_r <= 1'b0;
            prev_r <= 8'h00;
        end else begin
            go_r <= 1'b0;
            unique case (st_r)
                P_IDLE: begin
                    if (avs_write && ack_r && avs_address == REG_CTRL) begin
                        if (avs_writedata[CTRL_RESET]) begin
                            wr_r <= 1'b1;
                            go_r <= 1'b1;
                            busy_r <= 1'b1;
                            ret_r <= P_RST;
                            st_r <= P_WAIT;
                        end else if (avs_writedata[CTRL_START]) begin
                            // a fresh start always begins with two reads
                            wr_r <= 1'b0;
                            go_r <= 1'b1;
                            busy_r <= 1'b1;
                            done_r <= 1'b0;
                            fail_r <= 1'b0;
                            sel_r <= 1'b0;
                            ret_r <= P_RD1;
                            st_r <= P_WAIT;
                        end
                    end
                end
                P_WAIT: begin
                    if (cyc_done) begin
                        st_r <= ret_r;
                    end
                end
                P_RD1: begin
                    prev_r <= rdata;
                    go_r <= 1'b1;
                    ret_r <= P_RD2;
                    st_r <= P_WAIT;
                end
                P_RD2, P_RECHK: begin
                    prev_r <= rdata;
                    if (rdata[TOG2_BIT] != prev_r[TOG2_BIT]) begin
                        sel_r <= 1'b1;
                    end
                    go_r <= 1'b1;
                    if (op_done(rdata, prev_r, tog_r, erase_r, exp_r)) begin
                        ret_r <= P_FINAL;
                    end else if (st_r == P_RECHK) begin
                        // still busy after timeout: abort with reset
                        wr_r <= 1'b1;
                        fail_r <= 1'b1;
                        ret_r <= P_RST;
                    end else if (rdata[TMO_BIT]) begin
                        ret_r <= P_RECHK;
                    end else begin
                        ret_r <= P_RD2;
                    end
                    st_r <= P_WAIT;
                end
                P_FINAL: begin
                    busy_r <= 1'b0;
                    done_r <= 1'b1;
                    st_r <= P_IDLE;
                end
                P_RST: begin
                    wr_r <= 1'b0;
                    busy_r <= 1'b0;
                    done_r <= 1'b1;
                    st_r <= P_IDLE;
                end
            endcase
        end
    end
endmodule // fwsr_poller

// *** common/fwsr_pkg.sv ***
// Purpose: constants shared by the flash status poller
// Assumes: 100 MHz clock, flash is an asynchronous read/write device
// Notes: register offsets are byte addresses on the avalon slave
package fwsr_pkg;
    // avalon register byte offsets
    localparam logic [3:0] REG_CTRL = 4'h0;     // write: start/op/reset bits
    localparam logic [3:0] REG_ADDR = 4'h4;     // flash address to poll
    localparam logic [3:0] REG_DATA = 4'h8;     // expected datum / result
    localparam logic [3:0] REG_STAT = 4'hc;     // poller status
    // control field positions
    localparam int CTRL_START = 0;              // start polling
    localparam int CTRL_ERASE = 1;              // 1 = erase, 0 = program
    localparam int CTRL_TOGGLE = 2;             // 1 = toggle method
    localparam int CTRL_RESET = 3;              // issue reset command
    // status field positions
    localparam int STAT_BUSY = 0;
    localparam int STAT_DONE = 1;
    localparam int STAT_FAIL = 2;
    localparam int STAT_RDY = 3;                // ready/busy pin level
    localparam int STAT_SEL = 4;                // second toggle seen
    // flash data bit positions
    localparam int POLL_BIT = 7;
    localparam int TOG1_BIT = 6;
    localparam int TMO_BIT = 5;
    localparam int TOG2_BIT = 2;
    // flash commands
    localparam logic [7:0] CMD_RESET = 8'hf0;
    // flash bus cycle timing
    localparam int CYC_NS = 10;                 // clock period
    localparam int STROBE_NS = 80;              // strobe low time, least
    localparam int STROBE_CYC = (STROBE_NS + CYC_NS - 1) / CYC_NS;
    localparam int GAP_NS = 30;                 // strobe high time, least
    localparam int GAP_CYC = (GAP_NS + CYC_NS - 1) / CYC_NS;
    localparam int TW = 4;                      // timer width
    localparam logic [3:0] RST_CTRL = 4'h0;     // reset value of control
endpackage

// *** verilog/fwsr_bus_cycle.sv ***
// Purpose: one asynchronous read or write cycle on the flash pins
// Assumes: strobe low time and recovery time are whole clock counts
// Notes: done pulses for one clock after recovery
`timescale 1ns/1ps
module fwsr_bus_cycle
    import fwsr_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic go,
    input wire logic wr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] dq_in,
    output logic [7:0] rdata,
    output logic done,
    output logic oe_n,
    output logic we_n,
    output logic dq_oe_n
);
    import fwsr_pkg::*;
    typedef enum logic [2:0] {
        C_IDLE = 3'b001,
        C_STRB = 3'b010,
        C_GAP = 3'b100
    } fwsr_cyc_type;
    fwsr_cyc_type st_r; // cycle state
    logic [TW-1:0] cnt_r; // phase timer
    logic wr_r; // latched direction

    // cycle sequencer: strobe low, sample data on its rising edge, recover
    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= C_IDLE;
            cnt_r <= '0;
            wr_r <= 1'b0;
            oe_n <= 1'b1;
            we_n <= 1'b1;
            dq_oe_n <= 1'b1;
            rdata <= 8'h00;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            unique case (st_r)
                C_IDLE: begin
                    if (go) begin
                        wr_r <= wr;
                        oe_n <= wr;
                        we_n <= ~wr;
                        dq_oe_n <= ~wr;
                        cnt_r <= TW'(STROBE_CYC - 1);
                        st_r <= C_STRB;
                    end
                end
                C_STRB: begin
                    if (cnt_r == '0) begin
                        // data taken at the strobe's end, settled by then
                        if (!wr_r) begin
                            rdata <= dq_in;
                        end
                        oe_n <= 1'b1;
                        we_n <= 1'b1;
                        cnt_r <= TW'(GAP_CYC - 1);
                        st_r <= C_GAP;
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                C_GAP: begin
                    // data bus released only after write strobe rises
                    dq_oe_n <= 1'b1;
                    if (cnt_r == '0) begin
                        done <= 1'b1;
                        st_r <= C_IDLE;
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
            endcase
        end
    end
endmodule // fwsr_bus_cycle

// *** verification/fwsr_flash_model.sv ***
// Purpose: behavioural flash bank answering status reads
// Assumes: bench arms an operation before the poller starts
// Notes: no clock; state moves on strobe edges only
`timescale 1ns/1ps
module fwsr_flash_model (
    input wire logic [21:0] flash_addr,
    input wire logic [7:0] flash_dq_out,
    input wire logic flash_dq_oe_n,
    input wire logic flash_oe_n,
    input wire logic flash_we_n,
    output logic [7:0] flash_dq_in,
    output logic ready_busy_n
);
    import fwsr_pkg::*;
    logic busy_r = 1'b0; // embedded operation running
    logic erase_r = 1'b0; // erase when set, else program
    logic tmo_r = 1'b0; // pulse limit exceeded
    logic sel_r = 1'b0; // polled address lies in erase sector
    logic t1_r = 1'b0; // first toggle bit
    logic t2_r = 1'b0; // second toggle bit
    logic got_rst_r = 1'b0; // reset command seen
    logic prot_r = 1'b0; // every target sector protected
    logic susp_r = 1'b0; // bank sits in erase suspend
    logic [7:0] arr_r = 8'h00; // array content at the address
    logic [7:0] pd_r = 8'h00; // datum being programmed
    logic [7:0] last_r = 8'h00; // last value put on the bus
    logic [7:0] stat; // status byte
    int left_r = 0; // read cycles until the operation ends
    // bench sets up one operation; zero reads means idle bank
    task automatic arm(input logic er, input int n, input logic [7:0] d,
                       input logic tm, input logic sl);
        erase_r = er;
        left_r = n;
        busy_r = (n != 0);
        pd_r = d;
        tmo_r = tm;
        sel_r = sl;
        prot_r = 1'b0;
        susp_r = 1'b0;
        if (n == 0)
            arr_r = d;
    endtask
    // after arm: protected target, or erase suspended
    task automatic mode(input logic pr, input logic su);
        prot_r = pr;
        susp_r = su;
    endtask
    // status byte; erase timer bit high in erase
    assign stat = {erase_r ? susp_r : ~pd_r[7],
                   t1_r, tmo_r, 1'b0, erase_r, t2_r, 2'b00};
    // released bus shows the inverse so stale data never passes
    assign flash_dq_in = !flash_oe_n ? (busy_r ? stat : arr_r) : ~last_r;
    // suspended erase lets the pin go back high
    assign ready_busy_n = (busy_r && !susp_r) ? 1'b0 : 1'b1;
    // end of a read cycle advances the toggles
    always @(posedge flash_oe_n) begin
        last_r = busy_r ? stat : arr_r;
        if (busy_r) begin
            // suspend freezes the first toggle and the countdown
            if (!susp_r)
                t1_r = ~t1_r;
            if (sel_r)
                t2_r = ~t2_r;
            if (!susp_r)
                left_r = left_r - 1;
            if (left_r == 0) begin
                busy_r = 1'b0;
                // protected target: back to array reads, data kept
                if (!prot_r)
                    arr_r = erase_r ? 8'hff : pd_r;
            end
        end
    end
    // reset command ends any operation and clears the timeout
    always @(posedge flash_we_n) begin
        if (!flash_dq_oe_n && flash_dq_out == CMD_RESET) begin
            busy_r = 1'b0;
            tmo_r = 1'b0;
            got_rst_r = 1'b1;
        end
    end
endmodule // fwsr_flash_model

// *** verification/fwsr_poller_chk.sv ***
// Purpose: port-level checks of the flash status poller
// Assumes: single clock, synchronous active-high reset
// Notes: bound onto every poller instance
`timescale 1ns/1ps
module fwsr_poller_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic [21:0] flash_addr,
    input wire logic [7:0] flash_dq_out,
    input wire logic flash_dq_oe_n,
    input wire logic flash_oe_n,
    input wire logic flash_we_n
);
    import fwsr_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // slave answers one cycle after the request is seen
    answer_time_a: assert property ($rose(avs_read || avs_write)
        |=> !avs_waitrequest) else $error("late bus answer");
    answer_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer longer than one cycle");
    answer_cause_a: assert property (!avs_waitrequest
        |-> $past(avs_read || avs_write)) else $error("answer unasked");
    // both strobes low would corrupt the flash bus
    strobe_excl_a: assert property (!(!flash_oe_n && !flash_we_n))
        else $error("read and write strobes together");
    read_cycle_a: assert property ($fell(flash_oe_n) |->
        !flash_oe_n [*8] ##1 flash_oe_n [*3]) else $error("read cycle");
    write_cycle_a: assert property ($fell(flash_we_n) |->
        !flash_we_n [*8] ##1 flash_we_n) else $error("write cycle");
    reset_cmd_a: assert property (!flash_we_n |-> !flash_dq_oe_n &&
        flash_dq_out == CMD_RESET) else $error("bad reset command");
    read_float_a: assert property (!flash_oe_n |-> flash_dq_oe_n)
        else $error("host drives data during read");
    addr_hold_a: assert property (!flash_oe_n |-> $stable(flash_addr))
        else $error("address moved in read");
endmodule // fwsr_poller_chk
bind fwsr_poller fwsr_poller_chk fwsr_poller_chk_i (.clk(clk), .rst(rst),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .flash_addr(flash_addr),
    .flash_dq_out(flash_dq_out), .flash_dq_oe_n(flash_dq_oe_n),
    .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n));

// *** verification/fwsr_poller_tb.sv ***
// Purpose: self-checking bench for the flash status poller
// Assumes: flash model armed before each start
// Notes: avalon master holds requests until waitrequest low
`timescale 1ns/1ps
module fwsr_poller_tb;
    import fwsr_pkg::*;
    logic clk = 1'b0; // 100 MHz
    logic rst = 1'b1; // synchronous reset
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [21:0] flash_addr;
    logic [7:0] flash_dq_in, flash_dq_out;
    logic flash_dq_oe_n, flash_oe_n, flash_we_n, ready_busy_n;
    logic [31:0] rd; // last read data
    int fails = 0;
    int n_compared = 0;
    int cycles = 0;
    always #5 clk = ~clk;
    fwsr_poller fwsr_poller_i (.clk(clk), .rst(rst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .flash_addr(flash_addr), .flash_dq_in(flash_dq_in),
        .flash_dq_out(flash_dq_out), .flash_dq_oe_n(flash_dq_oe_n),
        .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
        .ready_busy_n(ready_busy_n));
    fwsr_flash_model fwsr_flash_model_i (.flash_addr(flash_addr),
        .flash_dq_out(flash_dq_out), .flash_dq_oe_n(flash_dq_oe_n),
        .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
        .flash_dq_in(flash_dq_in), .ready_busy_n(ready_busy_n));
    task automatic give_verdict();
        $display("compared %0d, failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time,
                     seen, exp);
        end
    endtask
    // one avalon transfer; an edge passes before the next one
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !w;
        avs_write <= w;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask
    // start, optionally see busy with pin low, wait, check status bits
    task automatic poll(input logic [3:0] ctl, input logic run,
                        input logic [31:0] exp, input logic [31:0] mask);
        int k;
        bus(1'b1, REG_CTRL, {28'h0, ctl});
        k = 0;
        do begin
            bus(1'b0, REG_STAT, 32'h0);
            if (k == 0 && run)
                check(rd & 32'h9, 32'h1);
            k++;
        end while (rd[STAT_BUSY] !== 1'b0 && k < 400);
        check(rd & mask, exp);
    endtask
    // hang guard well above the expected thousand or so cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            give_verdict();
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        bus(1'b0, REG_STAT, 32'h0);
        check(rd, 32'h8);
        bus(1'b0, 4'h2, 32'h0);
        check(rd, 32'h0);
        bus(1'b1, REG_ADDR, 32'h12345);
        fwsr_flash_model_i.arm(1'b0, 0, 8'h5a, 1'b0, 1'b0);
        poll(4'h5, 1'b0, 32'h2, 32'h7);
        check({10'h0, flash_addr}, 32'h12345);
        bus(1'b0, REG_DATA, 32'h0);
        check(rd & 32'hff, 32'h5a);
        fwsr_flash_model_i.arm(1'b0, 6, 8'h3c, 1'b0, 1'b0);
        poll(4'h5, 1'b1, 32'h2, 32'h7);
        bus(1'b0, REG_DATA, 32'h0);
        check(rd & 32'hff, 32'h3c);
        bus(1'b1, REG_DATA, 32'h81);
        fwsr_flash_model_i.arm(1'b0, 5, 8'h81, 1'b0, 1'b0);
        poll(4'h1, 1'b1, 32'h2, 32'h7);
        bus(1'b0, REG_DATA, 32'h0);
        check(rd & 32'hff, 32'h81);
        fwsr_flash_model_i.arm(1'b0, 3, 8'h00, 1'b0, 1'b0);
        fwsr_flash_model_i.mode(1'b1, 1'b0);
        poll(4'h5, 1'b1, 32'h2, 32'h7);
        bus(1'b0, REG_DATA, 32'h0);
        check(rd & 32'hff, 32'h81);
        fwsr_flash_model_i.arm(1'b1, 3, 8'h00, 1'b0, 1'b0);
        fwsr_flash_model_i.mode(1'b1, 1'b0);
        poll(4'h7, 1'b1, 32'h2, 32'h7);
        bus(1'b0, REG_DATA, 32'h0);
        check(rd & 32'hff, 32'h81);
        fwsr_flash_model_i.arm(1'b1, 2, 8'h00, 1'b0, 1'b1);
        fwsr_flash_model_i.mode(1'b0, 1'b1);
        poll(4'h3, 1'b0, 32'ha, 32'hf);
        fwsr_flash_model_i.arm(1'b1, 2, 8'h00, 1'b0, 1'b1);
        fwsr_flash_model_i.mode(1'b0, 1'b1);
        poll(4'h7, 1'b0, 32'h1a, 32'h1f);
        fwsr_flash_model_i.arm(1'b1, 4, 8'h00, 1'b0, 1'b0);
        poll(4'h3, 1'b1, 32'h2, 32'h7);
        bus(1'b0, REG_DATA, 32'h0);
        check(rd & 32'hff, 32'hff);
        fwsr_flash_model_i.arm(1'b1, 4, 8'h00, 1'b0, 1'b1);
        poll(4'h7, 1'b1, 32'h12, 32'h17);
        fwsr_flash_model_i.arm(1'b0, 255, 8'h55, 1'b1, 1'b0);
        poll(4'h5, 1'b1, 32'h4, 32'h5);
        check({31'h0, fwsr_flash_model_i.got_rst_r}, 32'h1);
        repeat (4) @(posedge clk);
        check({31'h0, ready_busy_n}, 32'h1);
        give_verdict();
    end
endmodule // fwsr_poller_tb
